// ---- hdl/cic_pkg.sv ----
// package: constants, types and helpers for the cascadable interrupt controller
// How it works
// [RULE_01] nested mode blocks lower priority than in-service
// [RULE_02] special mask blocks only in-service sources
// [RULE_03] mask register still gates each line
// [RULE_04] acknowledge sets in-service bit, master and slave
// [RULE_05] master ignores cascaded input while it is in service
// [RULE_06] special nested master passes equal or higher
// [RULE_07] host: slave end, read in-service, then master
// [RULE_08] host: special nested mode only in master
// [RULE_09] poll read replaces the acknowledge sequence
// [RULE_10] host masks its interrupt input before polling
// [RULE_11] cascade reaches sixty-four levels, more by polling
// [RULE_12] init words at setup, operation words afterwards
// [RULE_13] two locations: address, data and sequence select
// [RULE_14] read command selects register for next read
// [RULE_15] mask register readable directly
// [RULE_16] two consecutive locations per module
// [RULE_17] host initialises both before enabling interrupts
// [RULE_18] sequencer; out-of-order write leaves it lost
// [RULE_19] first init word restarts the sequencer
// [RULE_20] first init word: low address zero, bit four
// [RULE_21] first init word clears mask, modes, defaults
// [RULE_22] words two, three, four follow in order
// [RULE_23] word three only in cascade mode
// [RULE_24] type is five base bits plus line
// [RULE_25] word four only when flagged in word one
package cic_pkg;
  localparam int         NLINE           = 8;
  localparam int         LW              = 3;
  localparam int         INIT1_SEL_BIT   = 4;
  localparam int         INIT1_LEVEL_BIT = 3;
  localparam int         INIT1_SNGL_BIT  = 1;
  localparam int         INIT1_W4_BIT    = 0;
  localparam int         INIT4_SFNM_BIT  = 4;
  localparam int         INIT4_AEOI_BIT  = 1;
  localparam int         OPER3_SEL_BIT   = 3;
  localparam int         OPER2_SPEC_BIT  = 6;
  localparam int         OPER2_EOI_BIT   = 5;
  localparam int         OPER3_ESMM_BIT  = 6;
  localparam int         OPER3_SMM_BIT   = 5;
  localparam int         OPER3_POLL_BIT  = 2;
  localparam int         OPER3_RR_BIT    = 1;
  localparam int         OPER3_RIS_BIT   = 0;
  localparam int         BASE_LSB        = 3;
  localparam int         CAS_LEVELS      = 64;
  localparam logic [7:0] SLAVE_ID_DEF    = 8'h07;
  localparam logic [2:0] SPUR_LVL        = 3'h7;
  localparam logic [7:0] MASK_RST        = 8'h00;
  localparam logic [3:0] POLL_PAD        = 4'h0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       addr_low;
    logic [7:0] data;
  } cic_host_t;

  typedef struct packed {
    logic first;
    logic second;
  } cic_ack_t;

  typedef struct packed {
    logic level_mode;
    logic single;
    logic need4;
    logic sfnm;
    logic aeoi;
  } cic_cfg_t;

  typedef enum logic [5:0] {
    seq_reset = 6'h01,
    seq_w2    = 6'h02,
    seq_w3    = 6'h04,
    seq_w4    = 6'h08,
    seq_run   = 6'h10,
    seq_lost  = 6'h20
  } cic_seq_t;

  // highest priority set bit: {found, line}; line 0 is highest
  function automatic logic [3:0] cic_first(input logic [7:0] v);
    cic_first = 4'h0;
    for (int i = NLINE - 1; i >= 0; i--) begin
      if (v[i]) begin
        cic_first = {1'b1, 3'(i)};
      end
    end
  endfunction

  function automatic logic [7:0] cic_dec(input logic [2:0] l);
    cic_dec = 8'h01 << l;
  endfunction
endpackage

// ---- hdl/cic_edge.sv ----
// request line synchronisers, edge or level detection and request register
`timescale 1ns/100ps
module cic_edge (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] ir_pin,
  input  wire logic       level_mode,
  input  wire logic       edge_clr,
  input  wire logic [7:0] irr_clr,
  output wire logic [7:0] irr
);
  import cic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  generate
    for (genvar g = 0; g < NLINE; g++) begin : g_line
      logic s1_ff;
      logic s2_ff;
      logic prev_ff;
      logic irr_ff;
      wire  rise    = s2_ff & ~prev_ff;
      // set wins over clear so an edge during acknowledge is kept
      wire  nxt_irr = level_mode ? s2_ff : ((irr_ff & ~irr_clr[g]) | rise);
      assign irr[g] = irr_ff;
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_ff   <= 1'b0;
          s2_ff   <= 1'b0;
          prev_ff <= 1'b1;
          irr_ff  <= 1'b0;
        end else begin
          s1_ff <= ir_pin[g];
          s2_ff <= s1_ff;
          // after a restart a line in edge mode must go low before it counts again
          prev_ff <= edge_clr ? 1'b1 : s2_ff; // [RULE_21]
          irr_ff  <= edge_clr ? 1'b0 : nxt_irr; // [RULE_21]
        end
      end
    end
  endgenerate
endmodule

// ---- hdl/cic_prio.sv ----
// priority resolver: masking, nesting and special modes
`timescale 1ns/100ps
module cic_prio (
  input  wire logic [7:0] irr,
  input  wire logic [7:0] mask,
  input  wire logic [7:0] isr,
  input  wire logic       smm,
  input  wire logic       sfnm,
  output wire logic       hit,
  output wire logic [2:0] lvl
);
  import cic_pkg::*;

  wire [3:0] top_isr = cic_first(isr);
  wire [7:0] blk;

  ////////////////////////////////////////////////////////////////////////////
  generate
    for (genvar g = 0; g < NLINE; g++) begin : g_blk
      wire nest_blk = sfnm ? (3'(g) > top_isr[2:0])   // [RULE_06]
                           : (3'(g) >= top_isr[2:0]); // [RULE_01] [RULE_05]
      assign blk[g] = smm ? isr[g] : (top_isr[LW] & nest_blk); // [RULE_02]
    end
  endgenerate

  wire [7:0] pend = irr & ~mask & ~blk; // [RULE_03]
  wire [3:0] win  = cic_first(pend);

  assign hit = win[LW];
  assign lvl = win[2:0];
endmodule

// ---- hdl/cic_ctrl.sv ----
// one controller module: command words, sequencing, acknowledge, poll, reads
`timescale 1ns/100ps
module cic_ctrl (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire cic_pkg::cic_host_t host,
  input  wire cic_pkg::cic_ack_t  ack,
  input  wire logic              cfg_is_master,
  input  wire logic [7:0]        ir_pin,
  input  wire logic [2:0]        cas_in,
  output logic [7:0]             rd_data,
  output logic                   int_req,
  output logic [2:0]             cas_out,
  output logic                   cas_oe,
  output logic [7:0]             ack_type,
  output logic                   ack_type_vld,
  output logic                   init_done,
  output logic                   init_lost
);
  import cic_pkg::*;

  cic_seq_t   seq_ff;
  cic_seq_t   nxt_seq;
  cic_cfg_t   cfg_ff;
  logic [4:0] base_ff;
  logic [7:0] casmap_ff;
  logic [7:0] mask_ff;
  logic [7:0] isr_ff;
  logic       smm_ff;
  logic       rsel_ff;
  logic       poll_ff;
  logic       ack_pend_ff;
  logic       drive_ff;
  logic [2:0] ack_lvl_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] ack_type_ff;
  logic       ack_type_vld_ff;
  logic [2:0] cas_out_ff;
  logic       cas_oe_ff;
  logic       int_req_ff;
  logic       init_done_ff;
  logic       init_lost_ff;
  logic [7:0] irr;
  logic       hit;
  logic [2:0] lvl;

  ////////////////////////////////////////////////////////////////////////////
  // address and data decode
  wire is_run  = (seq_ff == seq_run);
  wire in_init = (seq_ff == seq_w2) | (seq_ff == seq_w3) | (seq_ff == seq_w4);
  wire wr_lo   = host.wr & ~host.addr_low; // [RULE_13] [RULE_16]
  wire wr_hi   = host.wr & host.addr_low;  // [RULE_13] [RULE_16]
  wire is_w1   = wr_lo & host.data[INIT1_SEL_BIT]; // [RULE_20]
  wire is_ow   = wr_lo & ~host.data[INIT1_SEL_BIT];
  wire is_o1   = is_run & wr_hi; // [RULE_12]
  wire is_o2   = is_run & is_ow & ~host.data[OPER3_SEL_BIT]; // [RULE_12]
  wire is_o3   = is_run & is_ow & host.data[OPER3_SEL_BIT];  // [RULE_12]
  wire wr_w2   = (seq_ff == seq_w2) & wr_hi;
  wire wr_w3   = (seq_ff == seq_w3) & wr_hi;
  wire wr_w4   = (seq_ff == seq_w4) & wr_hi;

  wire       cascade   = ~cfg_ff.single;
  wire       as_master = ~cascade | cfg_is_master;
  // nesting relief only makes sense where slaves hang below
  wire       sfnm_on   = cfg_ff.sfnm & cascade & cfg_is_master;
  wire [2:0] slave_id  = casmap_ff[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // request register and resolver
  wire [7:0] isr_set;

  cic_edge u_edge (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .ir_pin     (ir_pin),
    .level_mode (cfg_ff.level_mode),
    .edge_clr   (is_w1),
    .irr_clr    (isr_set),
    .irr        (irr)
  );

  cic_prio u_prio (
    .irr  (irr),
    .mask (mask_ff),
    .isr  (isr_ff),
    .smm  (smm_ff),
    .sfnm (sfnm_on),
    .hit  (hit),
    .lvl  (lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge, poll and end of service
  wire       take_first = ack.first & is_run & as_master;
  wire [2:0] ack_lvl    = hit ? lvl : SPUR_LVL;
  // a cascaded line hands the type over to the addressed slave
  wire       to_slave   = take_first & hit & cascade & casmap_ff[lvl]; // [RULE_11]
  // slave claims on the second pulse, while the master address stands
  wire       slave_take = ack.second & is_run & ~as_master & (cas_in == slave_id);
  wire       poll_rd    = host.rd & poll_ff & is_run; // [RULE_09]
  wire       grab       = hit & (take_first | slave_take | poll_rd);
  assign     isr_set    = grab ? cic_dec(lvl) : 8'h00; // [RULE_04] [RULE_09]

  wire [3:0] top_isr  = cic_first(isr_ff);
  wire       eoi_spec = host.data[OPER2_SPEC_BIT];
  wire [2:0] eoi_lvl  = eoi_spec ? host.data[2:0] : top_isr[2:0];
  wire       eoi_hit  = is_o2 & host.data[OPER2_EOI_BIT] & (eoi_spec | top_isr[LW]);
  wire       sec_own  = ack.second & ack_pend_ff;
  wire       aeoi_hit = sec_own & cfg_ff.aeoi & drive_ff;
  wire [7:0] isr_clr  = (eoi_hit ? cic_dec(eoi_lvl) : 8'h00)
                      | (aeoi_hit ? cic_dec(ack_lvl_ff) : 8'h00);
  // set wins: a new acknowledge of a line being ended keeps its bit
  wire [7:0] nxt_isr  = (isr_ff & ~isr_clr) | isr_set;

  wire       type_go  = (sec_own & drive_ff) | slave_take;
  wire [2:0] type_lvl = slave_take ? ack_lvl : ack_lvl_ff;

  ////////////////////////////////////////////////////////////////////////////
  // read path
  wire [7:0] poll_word = {hit, POLL_PAD, lvl};
  wire [7:0] stat_word = rsel_ff ? isr_ff : irr; // [RULE_14]
  wire [7:0] rd_mux    = poll_ff ? poll_word
                       : host.addr_low ? mask_ff : stat_word; // [RULE_15]

  ////////////////////////////////////////////////////////////////////////////
  // initialisation sequencer
  always_comb begin
    nxt_seq = seq_ff;
    if (is_w1) begin
      nxt_seq = seq_w2; // [RULE_19]
    end else begin
      unique case (seq_ff)
        seq_reset, seq_run, seq_lost: begin
          nxt_seq = seq_ff;
        end
        seq_w2: begin
          if (wr_hi) begin
            nxt_seq = cascade ? seq_w3 : (cfg_ff.need4 ? seq_w4 : seq_run); // [RULE_23]
          end else if (wr_lo) begin
            nxt_seq = seq_lost; // [RULE_18]
          end
        end
        seq_w3: begin
          if (wr_hi) begin
            nxt_seq = cfg_ff.need4 ? seq_w4 : seq_run; // [RULE_25]
          end else if (wr_lo) begin
            nxt_seq = seq_lost; // [RULE_18]
          end
        end
        seq_w4: begin
          if (wr_hi) begin
            nxt_seq = seq_run; // [RULE_22]
          end else if (wr_lo) begin
            nxt_seq = seq_lost; // [RULE_18]
          end
        end
        default: begin
          nxt_seq = seq_lost;
        end
      endcase
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_ff       <= seq_reset;
      init_done_ff <= 1'b0;
      init_lost_ff <= 1'b0;
    end else begin
      seq_ff       <= nxt_seq;
      init_done_ff <= (nxt_seq == seq_run);
      init_lost_ff <= (nxt_seq == seq_lost);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // initialisation words
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ff    <= '0;
      base_ff   <= '0;
      casmap_ff <= SLAVE_ID_DEF;
    end else if (is_w1) begin
      cfg_ff.level_mode <= host.data[INIT1_LEVEL_BIT];
      cfg_ff.single     <= host.data[INIT1_SNGL_BIT];
      cfg_ff.need4      <= host.data[INIT1_W4_BIT]; // [RULE_25]
      cfg_ff.sfnm       <= 1'b0;
      cfg_ff.aeoi       <= 1'b0;
      casmap_ff         <= SLAVE_ID_DEF; // [RULE_21]
    end else if (wr_w2) begin
      base_ff <= host.data[7:BASE_LSB]; // [RULE_24]
    end else if (wr_w3) begin
      casmap_ff <= host.data; // [RULE_23]
    end else if (wr_w4) begin
      cfg_ff.sfnm <= host.data[INIT4_SFNM_BIT];
      cfg_ff.aeoi <= host.data[INIT4_AEOI_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation words
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_ff <= MASK_RST;
      smm_ff  <= 1'b0;
      rsel_ff <= 1'b0;
      poll_ff <= 1'b0;
    end else if (is_w1) begin
      mask_ff <= MASK_RST; // [RULE_21]
      smm_ff  <= 1'b0;     // [RULE_21]
      rsel_ff <= 1'b0;     // [RULE_21]
      poll_ff <= 1'b0;
    end else begin
      if (is_o1) begin
        mask_ff <= host.data;
      end
      if (is_o3 & host.data[OPER3_ESMM_BIT]) begin
        smm_ff <= host.data[OPER3_SMM_BIT]; // [RULE_02]
      end
      if (is_o3 & host.data[OPER3_RR_BIT]) begin
        rsel_ff <= host.data[OPER3_RIS_BIT]; // [RULE_14]
      end
      // a poll covers exactly the next read, whichever location
      if (is_o3 & host.data[OPER3_POLL_BIT]) begin
        poll_ff <= 1'b1;
      end else if (host.rd) begin
        poll_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // in-service, acknowledge and outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      isr_ff      <= 8'h00;
      ack_pend_ff <= 1'b0;
      drive_ff    <= 1'b0;
      ack_lvl_ff  <= 3'h0;
      cas_out_ff  <= 3'h0;
      cas_oe_ff   <= 1'b0;
    end else begin
      isr_ff <= nxt_isr;
      if (take_first) begin
        ack_pend_ff <= 1'b1;
        drive_ff    <= ~to_slave;
        ack_lvl_ff  <= ack_lvl;
        cas_out_ff  <= to_slave ? lvl : 3'h0; // [RULE_04] [RULE_11]
        cas_oe_ff   <= to_slave;
      end else if (ack.second) begin
        ack_pend_ff <= 1'b0;
        drive_ff    <= 1'b0;
        cas_out_ff  <= 3'h0;
        cas_oe_ff   <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_ff      <= 8'h00;
      ack_type_ff     <= 8'h00;
      ack_type_vld_ff <= 1'b0;
      int_req_ff      <= 1'b0;
    end else begin
      if (host.rd) begin
        rd_data_ff <= rd_mux;
      end
      if (type_go) begin
        ack_type_ff <= {base_ff, type_lvl}; // [RULE_24]
      end
      ack_type_vld_ff <= type_go;
      // held off while a master acknowledge runs, so a request drops at the first pulse
      int_req_ff <= (nxt_seq == seq_run) & hit & ~(ack_pend_ff | take_first);
    end
  end
  assign rd_data      = rd_data_ff;
  assign ack_type     = ack_type_ff;
  assign ack_type_vld = ack_type_vld_ff;
  assign cas_out      = cas_out_ff;
  assign cas_oe       = cas_oe_ff;
  assign int_req      = int_req_ff;
  assign init_done    = init_done_ff;
  assign init_lost    = init_lost_ff;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  a_w1_defaults: assert property ( // [RULE_21]
    is_w1 |=> mask_ff == MASK_RST && !smm_ff && !rsel_ff && casmap_ff == SLAVE_ID_DEF)
    else $error("first init word did not restore defaults");
  a_w1_restart: assert property ( // [RULE_19]
    is_w1 |=> seq_ff == seq_w2)
    else $error("first init word did not restart sequence");
  a_w2_base: assert property ( // [RULE_22]
    wr_w2 |=> base_ff == $past(host.data[7:BASE_LSB]) && seq_ff != seq_w2)
    else $error("second init word not taken");
  a_w3_skip: assert property ( // [RULE_23]
    wr_w2 && cfg_ff.single |=> seq_ff != seq_w3)
    else $error("third init word expected in single mode");
  a_w4_flag: assert property ( // [RULE_25]
    (wr_w2 && cfg_ff.single || wr_w3) && !cfg_ff.need4 |=> seq_ff == seq_run)
    else $error("fourth init word expected without flag");
  // flag and state move on the same edge; a restart may follow at once
  a_seq_lost: assert property ( // [RULE_18]
    in_init && wr_lo && !is_w1 |=> seq_ff == seq_lost && init_lost)
    else $error("out-of-order write not flagged");
  a_mask_hold: assert property ( // [RULE_12]
    !is_run && !is_w1 |=> $stable(mask_ff))
    else $error("mask changed outside operation");
  a_mask_read: assert property ( // [RULE_15]
    host.rd && host.addr_low && !poll_ff |=> rd_data == $past(mask_ff))
    else $error("mask read wrong");
  a_isr_read: assert property ( // [RULE_14]
    host.rd && !host.addr_low && !poll_ff && rsel_ff |=> rd_data == $past(isr_ff))
    else $error("in-service read wrong");
  a_poll_grab: assert property ( // [RULE_09]
    poll_rd && hit |=> isr_ff[$past(lvl)] && rd_data[7])
    else $error("poll did not take request");
  a_smm_pass: assert property ( // [RULE_02]
    smm_ff && hit |-> !isr_ff[lvl])
    else $error("special mask passed in-service line");
  a_nest_block: assert property ( // [RULE_01]
    !smm_ff && !sfnm_on && hit && top_isr[LW] |-> lvl < top_isr[2:0])
    else $error("lower priority passed while nested");
  a_sfnm_equal: assert property ( // [RULE_06]
    !smm_ff && sfnm_on && hit && top_isr[LW] |-> lvl <= top_isr[2:0])
    else $error("special nested passed lower priority");
  a_mask_gate: assert property ( // [RULE_03]
    hit |-> !mask_ff[lvl] && irr[lvl])
    else $error("masked line resolved");
  a_cas_drive: assert property ( // [RULE_04]
    take_first && to_slave |=> cas_oe && cas_out == $past(lvl) && isr_ff[cas_out])
    else $error("cascade acknowledge wrong");
  a_type_build: assert property ( // [RULE_24]
    type_go |=> ack_type_vld && ack_type == {$past(base_ff), $past(type_lvl)})
    else $error("interrupt type wrong");
endmodule

// ---- bench/cic_host_model.sv ----
// host core model: command word writes, reads, end of service and acknowledges
`timescale 1ns/100ps
module cic_host_model (
  input  wire logic          mclk,
  input  wire logic [7:0]    rd_data,
  output cic_pkg::cic_host_t host,
  output cic_pkg::cic_ack_t  ack
);
  import cic_pkg::*;
  initial begin
    host = '0;
    ack  = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // released lines show the inverse, so stale values never look valid
  task automatic wr_word(input logic a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    host.wr       = 1'b1;
    host.addr_low = a;
    host.data     = d;
    @(posedge mclk);
    #1;
    host.wr   = 1'b0;
    host.data = ~d;
  endtask

  // read answer lands the cycle after the taking edge
  task automatic rd_word(input logic a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    host.rd       = 1'b1;
    host.addr_low = a;
    @(posedge mclk);
    #1;
    host.rd       = 1'b0;
    host.addr_low = ~a;
    d             = rd_data;
  endtask

  // only called on command, never from the request output
  task automatic strobe_ack(input logic sec);
    @(posedge mclk);
    #1;
    ack = sec ? 2'b01 : 2'b10;
    @(posedge mclk);
    #1;
    ack = 2'b00;
  endtask

  // whole sequence before any acknowledge
  // special nested only asked of a master
  task automatic init(input logic [7:0] w1, input logic [7:0] w2,
                      input logic [7:0] w3, input logic [7:0] w4);
    wr_word(1'b0, w1);
    wr_word(1'b1, w2);
    if (!w1[INIT1_SNGL_BIT]) begin
      wr_word(1'b1, w3);
    end
    if (w1[INIT1_W4_BIT]) begin
      wr_word(1'b1, w4);
    end
    @(posedge mclk);
    #1;
  endtask

  // specific end, then in-service read right after the command
  task automatic end_slave(input logic [2:0] l, output logic [7:0] isr);
    wr_word(1'b0, {3'h3, 2'h0, l});
    wr_word(1'b0, 8'h0b);
    rd_word(1'b0, isr);
  endtask
endmodule

// ---- bench/test_cic_ctrl.sv ----
// testbench for one controller module driven by the host model
`timescale 1ns/100ps
module test_cic_ctrl;
  import cic_pkg::*;
  logic       mclk;
  logic       sys_rst;
  logic       cfg_is_master;
  logic [7:0] ir_pin;
  logic [2:0] cas_in;
  cic_host_t  host;
  cic_ack_t   ack;
  logic [7:0] rd_data;
  logic       int_req;
  logic [2:0] cas_out;
  logic       cas_oe;
  logic [7:0] ack_type;
  logic       ack_type_vld;
  logic       init_done;
  logic       init_lost;
  logic [7:0] d;
  int         num_errors;
  int         n_tests;

  cic_ctrl uut (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .host          (host),
    .ack           (ack),
    .cfg_is_master (cfg_is_master),
    .ir_pin        (ir_pin),
    .cas_in        (cas_in),
    .rd_data       (rd_data),
    .int_req       (int_req),
    .cas_out       (cas_out),
    .cas_oe        (cas_oe),
    .ack_type      (ack_type),
    .ack_type_vld  (ack_type_vld),
    .init_done     (init_done),
    .init_lost     (init_lost)
  );

  cic_host_model p (
    .mclk    (mclk),
    .rd_data (rd_data),
    .host    (host),
    .ack     (ack)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // whole run is well under 1000 cycles
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors    = 0;
    n_tests       = 0;
    sys_rst       = 1'b1;
    cfg_is_master = 1'b0;
    ir_pin        = 8'h00;
    cas_in        = 3'h0;
    repeat (10) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    chk("init_done", 8'h00, {7'h0, init_done});
    // single mode, word four flagged: word three skipped
    p.init(8'h13, 8'h20, 8'h00, 8'h00);
    chk("init_done", 8'h01, {7'h0, init_done});
    p.wr_word(1'b1, 8'hf0);
    p.rd_word(1'b1, d);
    chk("mask", 8'hf0, d);
    ir_pin = 8'h04;
    wait_cyc(8);
    chk("int_req", 8'h01, {7'h0, int_req});
    p.strobe_ack(1'b0);
    p.strobe_ack(1'b1);
    chk("ack_type_vld", 8'h01, {7'h0, ack_type_vld});
    chk("ack_type", 8'h22, ack_type);
    chk("int_req", 8'h00, {7'h0, int_req});
    p.wr_word(1'b0, 8'h0b);
    p.rd_word(1'b0, d);
    chk("isr", 8'h04, d);
    // line three held back by nesting alone, line four by its mask bit
    ir_pin = 8'h1c;
    wait_cyc(8);
    chk("int_req", 8'h00, {7'h0, int_req});
    p.wr_word(1'b0, 8'h68);
    wait_cyc(8);
    chk("int_req", 8'h01, {7'h0, int_req});
    p.wr_word(1'b0, 8'h0c);
    p.rd_word(1'b0, d);
    chk("poll", 8'h83, d);
    // only masked line four left pending under special mask
    wait_cyc(1);
    chk("int_req", 8'h00, {7'h0, int_req});
    p.end_slave(3'h2, d);
    chk("isr", 8'h08, d);
    // out-of-order write, then restart
    p.wr_word(1'b0, 8'h13);
    p.wr_word(1'b0, 8'h00);
    wait_cyc(1);
    chk("init_lost", 8'h01, {7'h0, init_lost});
    p.wr_word(1'b1, 8'h55);
    p.init(8'h13, 8'h20, 8'h00, 8'h00);
    chk("init_lost", 8'h00, {7'h0, init_lost});
    chk("init_done", 8'h01, {7'h0, init_done});
    p.rd_word(1'b1, d);
    chk("mask", 8'h00, d);
    p.rd_word(1'b0, d);
    chk("irr", 8'h00, d);
    // restart keeps in-service bits, so line three must be ended here
    p.end_slave(3'h3, d);
    chk("isr", 8'h00, d);
    // cascade master, slave on line seven; plain then special nested
    cfg_is_master = 1'b1;
    for (int s = 0; s < 2; s++) begin
      ir_pin = 8'h00;
      p.init(8'h11, 8'h40, 8'h80, {3'h0, 1'(s), 4'h0});
      ir_pin = 8'h80;
      wait_cyc(8);
      chk("int_req", 8'h01, {7'h0, int_req});
      p.strobe_ack(1'b0);
      chk("cas_oe", 8'h01, {7'h0, cas_oe});
      chk("cas_out", 8'h07, {5'h0, cas_out});
      p.strobe_ack(1'b1);
      chk("cas_oe", 8'h00, {7'h0, cas_oe});
      chk("ack_type_vld", 8'h00, {7'h0, ack_type_vld});
      ir_pin = 8'h00;
      wait_cyc(4);
      ir_pin = 8'h80;
      wait_cyc(8);
      // blocked when plain, passed when special nested
      chk("int_req", {7'h0, 1'(s)}, {7'h0, int_req});
    end
    // slave with id five: the first pulse is not its own, the second is
    cfg_is_master = 1'b0;
    ir_pin        = 8'h00;
    cas_in        = 3'h5;
    p.init(8'h11, 8'h48, 8'h05, 8'h00);
    ir_pin = 8'h02;
    wait_cyc(8);
    chk("int_req", 8'h01, {7'h0, int_req});
    p.strobe_ack(1'b0);
    p.strobe_ack(1'b1);
    chk("ack_type_vld", 8'h01, {7'h0, ack_type_vld});
    chk("ack_type", 8'h49, ack_type);
    p.wr_word(1'b0, 8'h0b);
    p.rd_word(1'b0, d);
    chk("isr", 8'h82, d);
    give_verdict();
  end
endmodule
